// File: rtl/ubt_consts.svh
`ifndef UBT_CONSTS_SVH
`define UBT_CONSTS_SVH
`define UBT_BLS_16      3'h0
`define UBT_BLS_16_5    3'h1
`define UBT_BLS_15      3'h2
`define UBT_BLS_15_5    3'h3
`define UBT_BLS_17      3'h4
`define UBT_TICKS_15    5'h0f
`define UBT_TICKS_16    5'h10
`define UBT_TICKS_17    5'h11
`define UBT_SAMPLE_HI   5'h08
`define UBT_SAMPLE_MID  5'h07
`define UBT_SAMPLE_LO   5'h06
`define UBT_FILT_OFF    2'h0
`define UBT_FILT_ONE    2'h1
`define UBT_FILT_TWO    2'h2
`define UBT_NEED_ONE    4'h2
`define UBT_NEED_TWO    4'h4
`define UBT_NEED_FOUR   4'h8
`define UBT_DATA_BITS   4'h8
`define UBT_LAST_BIT    4'h7
`define UBT_ZERO_BIT    4'h0
`endif

// File: rtl/ubt_pkg.sv
`default_nettype none
package ubt_pkg;
  typedef enum logic [4:0] {
    UBT_TX_IDLE   = 5'b00001,
    UBT_TX_START  = 5'b00010,
    UBT_TX_DATA   = 5'b00100,
    UBT_TX_PARITY = 5'b01000,
    UBT_TX_STOP   = 5'b10000
  } ubt_tx_state_type;
  typedef enum logic [4:0] {
    UBT_RX_IDLE   = 5'b00001,
    UBT_RX_START  = 5'b00010,
    UBT_RX_DATA   = 5'b00100,
    UBT_RX_PARITY = 5'b01000,
    UBT_RX_STOP   = 5'b10000
  } ubt_rx_state_type;
endpackage
`default_nettype wire

// File: rtl/ubt_uart.sv
`include "ubt_consts.svh"
`default_nettype none
module ubt_uart #(
  parameter int DIV_W = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_base_clock_source_select,
  input  wire logic             i_alt_base_tick,
  input  wire logic [DIV_W-1:0] i_rate_divisor,
  input  wire logic [2:0]       i_bit_length_select,
  input  wire logic [1:0]       i_rx_glitch_filter_select,
  input  wire logic             i_transmit_enable_bit,
  input  wire logic             i_receive_enable_bit,
  input  wire logic             i_parity_enable,
  input  wire logic             i_parity_odd,
  input  wire logic             i_stop_bit_count_select,
  input  wire logic             i_infrared_polarity_select,
  input  wire logic             i_low_power_mode,
  input  wire logic             i_tx_write,
  input  wire logic [7:0]       i_transmit_buffer,
  input  wire logic             i_rx_read,
  input  wire logic             i_serial_in_pin,
  output logic                  o_serial_out_pin,
  output logic                  o_tx_buffer_full_flag,
  output logic                  o_tx_interrupt_request,
  output logic                  o_rx_buffer_full_flag,
  output logic [7:0]            o_receive_buffer,
  output logic                  o_rx_interrupt_request,
  output logic                  o_overrun_flag
);
  import ubt_pkg::*;

  if (DIV_W < 1 || DIV_W > 16) begin : g_div_w_check
    $error("DIV_W out of range");
  end

  // ----------------------------------------------------------------
  // Sub-tick generation
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_cnt_reg;
  logic             sub_tick_reg;
  logic             base_tick;
  assign base_tick = i_base_clock_source_select ? i_alt_base_tick : 1'b1;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_cnt_reg  <= '0;
      sub_tick_reg <= 1'b0;
    end else begin
      sub_tick_reg <= 1'b0;
      if (base_tick) begin
        if (div_cnt_reg >= i_rate_divisor) begin
          div_cnt_reg  <= '0;
          sub_tick_reg <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 1'b1;
        end
      end
    end
  end

  function automatic logic [4:0] bit_len(input logic [2:0] sel, input logic odd);
    logic [4:0] n;
    n = `UBT_TICKS_16;
    case (sel)
      `UBT_BLS_16_5: n = odd ? `UBT_TICKS_17 : `UBT_TICKS_16;
      `UBT_BLS_15:   n = `UBT_TICKS_15;
      `UBT_BLS_15_5: n = odd ? `UBT_TICKS_16 : `UBT_TICKS_15;
      `UBT_BLS_17:   n = `UBT_TICKS_17;
      default:       n = `UBT_TICKS_16;
    endcase
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Receive input synchroniser and glitch filter
  // ----------------------------------------------------------------
  logic       rx_meta_reg;
  logic       rx_sync_reg;
  logic       rx_filt_reg;
  logic       rx_prev_reg;
  logic [3:0] filt_cnt_reg;
  logic [3:0] filt_need;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= i_serial_in_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  always_comb begin
    case (i_rx_glitch_filter_select)
      `UBT_FILT_ONE: filt_need = `UBT_NEED_ONE;
      `UBT_FILT_TWO: filt_need = `UBT_NEED_TWO;
      default:       filt_need = `UBT_NEED_FOUR;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_filt_reg  <= 1'b1;
      filt_cnt_reg <= '0;
    end else if (i_rx_glitch_filter_select == `UBT_FILT_OFF || rx_sync_reg == rx_filt_reg) begin
      rx_filt_reg  <= (i_rx_glitch_filter_select == `UBT_FILT_OFF) ? rx_sync_reg : rx_filt_reg;
      filt_cnt_reg <= '0;
    end else if (base_tick && div_cnt_reg >= i_rate_divisor) begin
      if (filt_cnt_reg + 4'h1 >= filt_need) begin
        rx_filt_reg  <= rx_sync_reg;
        filt_cnt_reg <= '0;
      end else begin
        filt_cnt_reg <= filt_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) rx_prev_reg <= 1'b1;
    else rx_prev_reg <= rx_filt_reg;
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  ubt_rx_state_type rx_state_reg;
  logic [4:0]       rx_idx_reg;
  logic [3:0]       rx_bit_reg;
  logic             rx_odd_reg;
  logic [7:0]       rx_shift_reg;
  logic [2:0]       vote_reg;
  logic             stop_left_reg;
  logic             bit_val;
  logic             bit_end;
  logic [4:0]       rx_len;
  assign bit_val = (vote_reg[2] & vote_reg[1]) | (vote_reg[2] & vote_reg[0]) | (vote_reg[1] & vote_reg[0]);
  assign bit_end = sub_tick_reg && rx_idx_reg == 5'h0;
  assign rx_len  = bit_len(i_bit_length_select, rx_odd_reg);

  always_ff @(posedge i_clk) begin
    if (i_rst) vote_reg <= 3'h0;
    else if (sub_tick_reg && rx_idx_reg == `UBT_SAMPLE_HI) vote_reg[2] <= rx_filt_reg;
    else if (sub_tick_reg && rx_idx_reg == `UBT_SAMPLE_MID) vote_reg[1] <= rx_filt_reg;
    else if (sub_tick_reg && rx_idx_reg == `UBT_SAMPLE_LO) vote_reg[0] <= rx_filt_reg;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_state_reg           <= UBT_RX_IDLE;
      rx_idx_reg             <= '0;
      rx_bit_reg             <= '0;
      rx_odd_reg             <= 1'b0;
      rx_shift_reg           <= '0;
      stop_left_reg          <= 1'b0;
      o_receive_buffer       <= '0;
      o_rx_buffer_full_flag  <= 1'b0;
      o_rx_interrupt_request <= 1'b0;
      o_overrun_flag         <= 1'b0;
    end else begin
      o_rx_interrupt_request <= 1'b0;
      if (i_rx_read) begin
        o_rx_buffer_full_flag <= 1'b0;
        o_overrun_flag        <= 1'b0;
      end
      if (rx_state_reg != UBT_RX_IDLE && sub_tick_reg && rx_idx_reg != 5'h0) begin
        rx_idx_reg <= rx_idx_reg - 5'h1;
      end
      unique case (rx_state_reg)
        UBT_RX_IDLE: begin
          if (i_receive_enable_bit && rx_prev_reg && !rx_filt_reg) begin
            rx_state_reg <= UBT_RX_START;
            rx_idx_reg   <= bit_len(i_bit_length_select, 1'b0) - 5'h1;
            rx_odd_reg   <= 1'b1;
          end
        end
        UBT_RX_START: if (bit_end) begin
          if (bit_val) rx_state_reg <= UBT_RX_IDLE;
          else begin
            rx_state_reg <= UBT_RX_DATA;
            rx_bit_reg   <= `UBT_ZERO_BIT;
          end
          rx_idx_reg <= rx_len - 5'h1;
          rx_odd_reg <= ~rx_odd_reg;
        end
        UBT_RX_DATA: if (bit_end) begin
          rx_shift_reg <= {bit_val, rx_shift_reg[7:1]};
          rx_bit_reg   <= rx_bit_reg + 4'h1;
          if (rx_bit_reg == `UBT_LAST_BIT) begin
            rx_state_reg  <= i_parity_enable ? UBT_RX_PARITY : UBT_RX_STOP;
            stop_left_reg <= i_stop_bit_count_select;
          end
          rx_idx_reg <= rx_len - 5'h1;
          rx_odd_reg <= ~rx_odd_reg;
        end
        UBT_RX_PARITY: if (bit_end) begin
          rx_state_reg <= UBT_RX_STOP;
          rx_idx_reg   <= rx_len - 5'h1;
          rx_odd_reg   <= ~rx_odd_reg;
        end
        UBT_RX_STOP: if (bit_end) begin
          rx_idx_reg <= rx_len - 5'h1;
          rx_odd_reg <= ~rx_odd_reg;
          if (stop_left_reg) stop_left_reg <= 1'b0;
          else begin
            rx_state_reg <= UBT_RX_IDLE;
            if (o_rx_buffer_full_flag && !i_rx_read) begin
              if (!o_overrun_flag) o_rx_interrupt_request <= 1'b1;
              o_overrun_flag <= 1'b1;
            end else begin
              o_receive_buffer       <= rx_shift_reg;
              o_rx_buffer_full_flag  <= 1'b1;
              o_rx_interrupt_request <= 1'b1;
            end
          end
        end
        default: rx_state_reg <= UBT_RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  ubt_tx_state_type tx_state_reg;
  logic [4:0]       tx_idx_reg;
  logic [3:0]       tx_bit_reg;
  logic             tx_odd_reg;
  logic [7:0]       tx_hold_reg;
  logic [7:0]       tx_shift_reg;
  logic             tx_line_reg;
  logic             tx_started_reg;
  logic             tx_stop_left_reg;
  logic             tx_end;
  logic [4:0]       tx_len;
  assign tx_end = sub_tick_reg && tx_idx_reg == 5'h0;
  assign tx_len = bit_len(i_bit_length_select, tx_odd_reg);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_state_reg           <= UBT_TX_IDLE;
      tx_idx_reg             <= '0;
      tx_bit_reg             <= '0;
      tx_odd_reg             <= 1'b0;
      tx_hold_reg            <= '0;
      tx_shift_reg           <= '0;
      tx_line_reg            <= 1'b1;
      tx_started_reg         <= 1'b0;
      tx_stop_left_reg       <= 1'b0;
      o_tx_buffer_full_flag  <= 1'b0;
      o_tx_interrupt_request <= 1'b0;
    end else begin
      o_tx_interrupt_request <= 1'b0;
      if (!i_transmit_enable_bit) tx_started_reg <= 1'b0;
      if (i_tx_write) begin
        tx_hold_reg           <= i_transmit_buffer;
        o_tx_buffer_full_flag <= 1'b1;
        tx_started_reg        <= 1'b1;
      end
      if (tx_state_reg != UBT_TX_IDLE && sub_tick_reg && tx_idx_reg != 5'h0) tx_idx_reg <= tx_idx_reg - 5'h1;
      unique case (tx_state_reg)
        UBT_TX_IDLE: begin
          tx_line_reg <= 1'b1;
          if (o_tx_buffer_full_flag && !i_tx_write && i_transmit_enable_bit && sub_tick_reg) begin
            o_tx_buffer_full_flag  <= 1'b0;
            o_tx_interrupt_request <= 1'b1;
            tx_shift_reg           <= tx_hold_reg;
            tx_state_reg           <= UBT_TX_START;
            tx_line_reg            <= 1'b0;
            tx_idx_reg             <= bit_len(i_bit_length_select, 1'b0) - 5'h1;
            tx_odd_reg             <= 1'b1;
          end
        end
        UBT_TX_START: if (tx_end) begin
          tx_state_reg <= UBT_TX_DATA;
          tx_bit_reg   <= `UBT_ZERO_BIT;
          tx_line_reg  <= tx_shift_reg[0];
          tx_idx_reg   <= tx_len - 5'h1;
          tx_odd_reg   <= ~tx_odd_reg;
        end
        UBT_TX_DATA: if (tx_end) begin
          tx_idx_reg <= tx_len - 5'h1;
          tx_odd_reg <= ~tx_odd_reg;
          tx_bit_reg <= tx_bit_reg + 4'h1;
          if (tx_bit_reg == `UBT_LAST_BIT) begin
            tx_stop_left_reg <= i_stop_bit_count_select;
            tx_state_reg     <= i_parity_enable ? UBT_TX_PARITY : UBT_TX_STOP;
            tx_line_reg      <= i_parity_enable ? ((^tx_shift_reg) ^ i_parity_odd) : 1'b1;
          end else begin
            tx_line_reg <= tx_shift_reg[tx_bit_reg[2:0] + 3'h1];
          end
        end
        UBT_TX_PARITY: if (tx_end) begin
          tx_state_reg <= UBT_TX_STOP;
          tx_line_reg  <= 1'b1;
          tx_idx_reg   <= tx_len - 5'h1;
          tx_odd_reg   <= ~tx_odd_reg;
        end
        UBT_TX_STOP: if (tx_end) begin
          tx_idx_reg <= tx_len - 5'h1;
          tx_odd_reg <= ~tx_odd_reg;
          if (tx_stop_left_reg) tx_stop_left_reg <= 1'b0;
          else tx_state_reg <= UBT_TX_IDLE;
        end
        default: tx_state_reg <= UBT_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) o_serial_out_pin <= 1'b1;
    else if (!i_transmit_enable_bit || !tx_started_reg || i_low_power_mode) o_serial_out_pin <= ~i_infrared_polarity_select;
    else o_serial_out_pin <= tx_line_reg ^ i_infrared_polarity_select;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_idle_pin_level: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_transmit_enable_bit |=> o_serial_out_pin == ~$past(i_infrared_polarity_select))
    else $error("tx pin not idle while disabled");
  a_write_sets_full: assert property (@(posedge i_clk) disable iff (i_rst)
    i_tx_write |=> o_tx_buffer_full_flag)
    else $error("tx full flag not set on write");
  a_start_irq_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tx_interrupt_request |-> !o_tx_buffer_full_flag && $past(o_tx_buffer_full_flag))
    else $error("tx irq without flag clear");
  a_subtick_period: assert property (@(posedge i_clk) disable iff (i_rst)
    (sub_tick_reg && !i_base_clock_source_select && i_rate_divisor == DIV_W'(1)) ##1
    (!i_base_clock_source_select && i_rate_divisor == DIV_W'(1)) |-> !sub_tick_reg ##1 sub_tick_reg)
    else $error("sub-tick period wrong");
  a_idx_bound: assert property (@(posedge i_clk) disable iff (i_rst)
    rx_idx_reg <= `UBT_TICKS_17 - 5'h1)
    else $error("rx index over range");
  a_false_start: assert property (@(posedge i_clk) disable iff (i_rst)
    (rx_state_reg == UBT_RX_START && bit_end && bit_val) |=> rx_state_reg == UBT_RX_IDLE)
    else $error("false start not abandoned");
  a_overrun_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_overrun_flag && !$past(o_overrun_flag)) |-> $stable(o_receive_buffer))
    else $error("overrun changed buffer");
  a_rx_deliver: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(o_receive_buffer) |-> o_rx_buffer_full_flag && o_rx_interrupt_request)
    else $error("rx buffer change without flag");
endmodule // ubt_uart
`default_nettype wire

// File: tb/ubt_remote.sv
`default_nettype none
module ubt_remote (
  input  wire logic i_clk,
  input  wire logic i_line_in,
  output logic      o_line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int          bit_cyc = 32;
  int          nbits   = 10;
  logic [10:0] frame;
  logic [10:0] rx_q[$];
  logic        v;
  // ----------------------------------------
  // Receiver: samples every bit after the start bit at its middle.
  // ----------------------------------------
  // frame capture
  initial begin
    o_line_out = 1'b1;
    forever begin
      @(negedge i_line_in);
      frame = '0;
      repeat (bit_cyc / 2) @(posedge i_clk);
      for (int i = 0; i < nbits - 1; i++) begin
        repeat (bit_cyc) @(posedge i_clk);
        frame[i] = i_line_in;
      end
      rx_q.push_back(frame);
    end
  end
  // ----------------------------------------
  // Sender: bits LSB first, optional inverted span.
  // ----------------------------------------
  // exact bit period
  task automatic drive(input logic [11:0] bits, input int nb, input int cyc, input int g_at, input int g_len);
    for (int c = 0; c < nb * cyc; c++) begin
      v = bits[c / cyc];
      if (c >= g_at && c < g_at + g_len) v = ~v;
      @(posedge i_clk);
      #1 o_line_out = v;
    end
    @(posedge i_clk);
    #1 o_line_out = 1'b1;
  endtask
endmodule // ubt_remote
`default_nettype wire

// File: tb/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic       i_base_clock_source_select = 1'b0;
  logic       i_alt_base_tick = 1'b1;
  logic [7:0] i_rate_divisor = 8'h01;
  logic [2:0] i_bit_length_select = 3'h0;
  logic [1:0] i_rx_glitch_filter_select = 2'h0;
  logic       i_transmit_enable_bit = 1'b0;
  logic       i_receive_enable_bit = 1'b0;
  logic       i_parity_enable = 1'b0;
  logic       i_parity_odd = 1'b0;
  logic       i_stop_bit_count_select = 1'b0;
  logic       i_infrared_polarity_select = 1'b0;
  logic       i_low_power_mode = 1'b0;
  logic       i_tx_write = 1'b0;
  logic [7:0] i_transmit_buffer = 8'h00;
  logic       i_rx_read = 1'b0;
  logic       i_serial_in_pin;
  logic       o_serial_out_pin, o_tx_buffer_full_flag, o_tx_interrupt_request;
  logic       o_rx_buffer_full_flag, o_rx_interrupt_request, o_overrun_flag;
  logic [7:0] o_receive_buffer, d, m_buf;
  logic       m_full, m_ovr;
  int         errors, n_compared, n_rx_irq, m_irq, t, k;
  int         seed = 32'h03dcdb56;
  ubt_uart #(.DIV_W(8)) dut_u (.i_clk, .i_rst, .i_base_clock_source_select, .i_alt_base_tick, .i_rate_divisor,
    .i_bit_length_select, .i_rx_glitch_filter_select, .i_transmit_enable_bit, .i_receive_enable_bit,
    .i_parity_enable, .i_parity_odd, .i_stop_bit_count_select, .i_infrared_polarity_select, .i_low_power_mode,
    .i_tx_write, .i_transmit_buffer, .i_rx_read, .i_serial_in_pin, .o_serial_out_pin, .o_tx_buffer_full_flag,
    .o_tx_interrupt_request, .o_rx_buffer_full_flag, .o_receive_buffer, .o_rx_interrupt_request, .o_overrun_flag);
  ubt_remote remote_u (.i_clk(i_clk), .i_line_in(o_serial_out_pin), .o_line_out(i_serial_in_pin));
  // ----------------------------------------
  // Clock, watchdog and interrupt counting.
  // ----------------------------------------
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  initial begin
    repeat (60000) @(posedge i_clk);
    errors++;
    summarize();
  end
  always @(posedge i_clk) begin
    if (o_rx_interrupt_request === 1'b1) n_rx_irq++;
  end
  // ----------------------------------------
  // Reference model and helpers.
  // ----------------------------------------
  function automatic int ticks(input int sel, input int i);
    case (sel)
      1: return (i % 2) ? 17 : 16;
      2: return 15;
      3: return (i % 2) ? 16 : 15;
      4: return 17;
      default: return 16;
    endcase
  endfunction
  function automatic logic [10:0] fword(input logic [7:0] b);
    return {2'b11, i_parity_enable ? (^b ^ i_parity_odd) : 1'b1, b};
  endfunction
  function automatic int run_len(input logic [7:0] b);
    logic [11:0] w;
    int n, s;
    w = {fword(b), 1'b0};
    n = 0;
    s = 0;
    while (w[n] == 1'b0) begin
      s += ticks(i_bit_length_select, n) * (i_rate_divisor + 1);
      n++;
    end
    return s;
  endfunction
  function automatic logic [7:0] rnd8();
    return 8'($random(seed));
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cfg(input int sel, input logic [7:0] dv, input logic pe, input logic po, input logic sb,
                     input logic [1:0] fl);
    i_bit_length_select = 3'(sel);
    i_rate_divisor = dv;
    i_parity_enable = pe;
    i_parity_odd = po;
    i_stop_bit_count_select = sb;
    i_rx_glitch_filter_select = fl;
    remote_u.bit_cyc = (ticks(sel, 0) + ticks(sel, 1)) * (dv + 1) / 2;
    remote_u.nbits = 10 + pe + sb;
    tick(1);
  endtask
  task automatic tx(input logic [7:0] b, input bit dbl);
    int w;
    chk("tx full before write", 0, o_tx_buffer_full_flag);
    if (dbl) begin
      i_alt_base_tick = 1'b0;
      i_transmit_buffer = ~b;
      i_tx_write = 1'b1;
      tick(1);
    end
    i_transmit_buffer = b;
    i_tx_write = 1'b1;
    tick(1);
    i_tx_write = 1'b0;
    chk("tx full flag", 1, o_tx_buffer_full_flag);
    i_alt_base_tick = 1'b1;
    for (k = 0; k < 600 && o_tx_interrupt_request !== 1'b1; k++) tick(1);
    chk("tx irq", 1, o_tx_interrupt_request);
    chk("tx full cleared", 0, o_tx_buffer_full_flag);
    for (k = 0; k < 8 && o_serial_out_pin !== 1'b0; k++) tick(1);
    for (w = 0; w < 2000 && o_serial_out_pin === 1'b0; w++) tick(1);
    chk("low run cycles", run_len(b), w);
    for (k = 0; k < 3000 && remote_u.rx_q.size() == 0; k++) tick(1);
    chk("tx frame", fword(b) & (11'h7ff >> (2 - i_parity_enable - i_stop_bit_count_select)),
        remote_u.rx_q.pop_front());
    tick(remote_u.bit_cyc);
  endtask
  task automatic rx(input logic [7:0] b, input int g_at, input int g_len, input logic [7:0] e);
    remote_u.drive({fword(b), 1'b0}, remote_u.nbits, remote_u.bit_cyc, g_at, g_len);
    if (i_receive_enable_bit) begin
      if (!m_full) begin
        m_buf = e;
        m_full = 1'b1;
        m_irq++;
      end else if (!m_ovr) begin
        m_ovr = 1'b1;
        m_irq++;
      end
    end
    for (k = 0; k < 3 * remote_u.bit_cyc && n_rx_irq != m_irq; k++) tick(1);
    tick(2);
    chk("rx irq count", m_irq, n_rx_irq);
    chk("rx buffer", m_buf, o_receive_buffer);
    chk("rx full flag", m_full, o_rx_buffer_full_flag);
    chk("overrun flag", m_ovr, o_overrun_flag);
  endtask
  task automatic rd();
    i_rx_read = 1'b1;
    tick(1);
    i_rx_read = 1'b0;
    tick(1);
    m_full = 1'b0;
    m_ovr = 1'b0;
    chk("rx full after read", 0, o_rx_buffer_full_flag);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    m_buf = 8'h00;
    m_full = 1'b0;
    m_ovr = 1'b0;
    tick(8);
    i_rst = 1'b0;
    chk("line after reset", 1, o_serial_out_pin);
    chk("state after reset", 0, {o_tx_buffer_full_flag, o_rx_buffer_full_flag, o_overrun_flag, o_receive_buffer});
    i_transmit_enable_bit = 1'b1;
    i_receive_enable_bit = 1'b1;
    tick(4);
    chk("idle before write", 1, o_serial_out_pin);
    for (t = 0; t < 10; t++) begin
      cfg(t % 5, (t % 2) ? 8'h01 : 8'h03, t >= 5, 1'($random(seed)), t % 2, 2'(t));
      i_base_clock_source_select = t[1];
      tx((t % 3 == 0) ? 8'h00 : rnd8(), t == 7);
      d = rnd8();
      rx(d, 0, 0, d);
      if (t % 4 == 3) rx(rnd8(), 0, 0, 8'h00);
      rd();
    end
    cfg(0, 8'h01, 1'b0, 1'b0, 1'b0, 2'h0);
    remote_u.drive(12'hfff, 2, 32, 0, 10);
    d = rnd8();
    rx(d, 0, 0, d);
    rd();
    for (t = 0; t < 4; t++) begin
      cfg(0, 8'h01, 1'b0, 1'b0, 1'b0, 2'(t));
      d = rnd8() & 8'hfe;
      rx(d, 42, 12, (t == 3) ? d : (d | 8'h01));
      rd();
    end
    i_receive_enable_bit = 1'b0;
    d = rnd8();
    rx(d, 0, 0, d);
    i_low_power_mode = 1'b1;
    tx_low_power();
    i_infrared_polarity_select = 1'b1;
    tick(3);
    chk("infrared idle level", 0, o_serial_out_pin);
    i_low_power_mode = 1'b0;
    i_transmit_enable_bit = 1'b0;
    tick(3);
    chk("disabled idle low", 0, o_serial_out_pin);
    i_infrared_polarity_select = 1'b0;
    tick(3);
    chk("disabled idle high", 1, o_serial_out_pin);
    summarize();
  end
  task automatic tx_low_power();
    int lows;
    lows = 0;
    i_transmit_buffer = 8'h00;
    i_tx_write = 1'b1;
    tick(1);
    i_tx_write = 1'b0;
    repeat (400) begin
      tick(1);
      if (o_serial_out_pin !== 1'b1) lows++;
    end
    chk("low power line", 0, lows);
  endtask
endmodule // testbench
`default_nettype wire
